// ===== uic_pkg.sv
/*
  Constants and carriers for the interrupt and queue control block.
  Assumes the datapath outside supplies queue levels and line events.
*/
`default_nettype none
package uic_pkg;
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_MASK = 3'h1;
  localparam logic [2:0] IDX_ISR  = 3'h2;
  localparam logic [2:0] IDX_MCR  = 3'h4;
  localparam logic [2:0] IDX_LSR  = 3'h5;
  localparam logic [2:0] IDX_MSR  = 3'h6;
  localparam int         IDX_LO   = 2;
  localparam int         IDX_HI   = 4;
  localparam logic [3:0] ISR_LINE = 4'h6;
  localparam logic [3:0] ISR_TOUT = 4'hc;
  localparam logic [3:0] ISR_RXD  = 4'h4;
  localparam logic [3:0] ISR_TXR  = 4'h2;
  localparam logic [3:0] ISR_MDM  = 4'h0;
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam int M_RXD = 0;
  localparam int M_TXR = 1;
  localparam int M_LINE = 2;
  localparam int M_MDM = 3;
  localparam int F_EN = 0;
  localparam int F_RXCLR = 1;
  localparam int F_TXCLR = 2;
  localparam int F_TRIG = 6;
  localparam int MCR_IRQ = 3;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [4:0] MCR_RST  = 5'h00;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [7:0] TRIG_MIN = 8'h01;
  localparam logic [7:0] TOUT_CHARS = 8'h04;
  localparam logic [7:0] TOUT_BITS  = 8'h0c;
  typedef struct packed {
    logic [7:0] rx_level;
    logic       rx_char_in;
    logic [7:0] rx_data;
    logic [2:0] head_err;
    logic       fifo_err;
    logic       overrun;
    logic       tx_empty;
    logic       tx_idle;
    logic [7:0] modem_status;
    logic       bit_tick;
    logic [3:0] char_bits;
  } uic_stat_t;
  typedef struct packed {
    logic       fifo_en;
    logic       rx_clr;
    logic       tx_clr;
    logic       rx_pop;
    logic       tx_push;
    logic [7:0] tx_data;
    logic       msr_clr;
  } uic_ctl_t;
endpackage
`default_nettype wire

// ===== uic_ctrl.sv
/*
  Interrupt mask, prioritised interrupt status and queue control of one
  serial channel, reached over APB. Assumes the serial datapath drives
  the status struct synchronously to pclk and obeys the control pulses.
*/
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module uic_ctrl
  import uic_pkg::*;
#(
  parameter int         ADDR_W = 12,
  parameter logic [7:0] TRIG1  = 8'h08,
  parameter logic [7:0] TRIG2  = 8'h10,
  parameter logic [7:0] TRIG3  = 8'h20
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire uic_stat_t         stat,
  output uic_ctl_t               ctl,
  output logic                   irq
);
  generate
    if (ADDR_W <= IDX_HI || TRIG1 == 8'h00 || TRIG2 == 8'h00
        || TRIG3 == 8'h00) begin : g_bad
      $error("uic_ctrl: address too narrow or zero trigger");
    end
  endgenerate

  // Register index decode, shared by the read mux and every strobe.
  function automatic logic fn_sel(input logic [ADDR_W-1:0] a,
                                  input logic [2:0] i);
    fn_sel = (a[IDX_HI:IDX_LO] == i) && (a[IDX_LO-1:0] == '0)
             && (a[ADDR_W-1:IDX_HI+1] == '0);
  endfunction

  function automatic logic [7:0] fn_trig(input logic [1:0] s);
    unique case (s)
      2'h0: fn_trig = TRIG_MIN;
      2'h1: fn_trig = TRIG1;
      2'h2: fn_trig = TRIG2;
      2'h3: fn_trig = TRIG3;
    endcase
  endfunction

  logic            pready_reg;
  logic [31:0]     prdata_reg;
  logic            pslverr_reg;
  logic            irq_reg;
  uic_ctl_t        ctl_reg;
  logic [3:0]      mask_reg;
  logic [4:0]      mcr_reg;
  logic [1:0]      trig_reg;
  logic            ovr_reg;
  logic [2:0]      err_reg;
  logic [2:0]      herr_q_reg;
  logic            txe_q_reg;
  logic            txr_reg;
  logic [7:0]      tout_cnt_reg;
  logic            tout_reg;
  logic [3:0]      isr_reg;
  logic [3:0]      code_next;
  logic [7:0]      rd_next;
  logic            hit_next;

  logic phase, done, rd, wr;
  logic rd_data, rd_isr, rd_lsr, rd_msr, wr_data, wr_mask, wr_fcr, wr_mcr;
  logic rx_any, rxd_cond, line_cond, txr_set, tout_run, tout_hit;
  logic line_p, tout_p, rxd_p, txr_p, mdm_p;
  logic [7:0] tout_limit, lsr_val;

  assign phase   = psel & penable & ~pready_reg;
  assign done    = psel & penable & pready_reg;
  assign rd      = done & ~pwrite;
  assign wr      = done & pwrite;
  assign rd_data = rd & fn_sel(paddr, IDX_DATA);
  assign rd_isr  = rd & fn_sel(paddr, IDX_ISR);
  assign rd_lsr  = rd & fn_sel(paddr, IDX_LSR);
  assign rd_msr  = rd & fn_sel(paddr, IDX_MSR);
  assign wr_data = wr & fn_sel(paddr, IDX_DATA);
  assign wr_mask = wr & fn_sel(paddr, IDX_MASK);
  assign wr_fcr  = wr & fn_sel(paddr, IDX_ISR);
  assign wr_mcr  = wr & fn_sel(paddr, IDX_MCR);

  assign rx_any   = stat.rx_level != '0;
  assign lsr_val  = {stat.fifo_err, stat.tx_idle, stat.tx_empty,
                     err_reg, ovr_reg, rx_any};
  assign rxd_cond = ctl_reg.fifo_en ? (stat.rx_level >= fn_trig(trig_reg))
                                    : rx_any;
  assign line_cond = ovr_reg | (|err_reg);
  assign txr_set  = (stat.tx_empty & ~txe_q_reg)
                    | (wr_mask & pwdata[M_TXR] & ~mask_reg[M_TXR]
                       & stat.tx_empty);

  // Gating every source by its mask bit is what makes polled mode.
  assign line_p = mask_reg[M_LINE] & line_cond;
  assign tout_p = mask_reg[M_RXD] & tout_reg;
  assign rxd_p  = mask_reg[M_RXD] & rxd_cond;
  assign txr_p  = mask_reg[M_TXR] & txr_reg;
  assign mdm_p  = mask_reg[M_MDM] & (|stat.modem_status[3:0]);

  always_comb begin
    if (line_p)      code_next = ISR_LINE;
    else if (tout_p) code_next = ISR_TOUT;
    else if (rxd_p)  code_next = ISR_RXD;
    else if (txr_p)  code_next = ISR_TXR;
    else if (mdm_p)  code_next = ISR_MDM;
    else             code_next = ISR_NONE;
  end

  always_comb begin
    hit_next = 1'b1;
    rd_next  = 8'h00;
    if (fn_sel(paddr, IDX_DATA)) begin
      rd_next = pwrite ? 8'h00 : stat.rx_data;
    end else if (fn_sel(paddr, IDX_MASK)) begin
      rd_next = {4'h0, mask_reg};
    end else if (fn_sel(paddr, IDX_ISR)) begin
      rd_next = pwrite ? 8'h00 : {ctl_reg.fifo_en, ctl_reg.fifo_en,
                2'h0, isr_reg};
    end else if (fn_sel(paddr, IDX_MCR)) begin
      rd_next = {3'h0, mcr_reg};
    end else if (fn_sel(paddr, IDX_LSR)) begin
      rd_next = pwrite ? 8'h00 : lsr_val;
    end else if (fn_sel(paddr, IDX_MSR)) begin
      rd_next = pwrite ? 8'h00 : stat.modem_status;
    end else begin
      hit_next = 1'b0;
    end
  end

  // One wait cycle lets the read mux settle on a registered answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= phase;
      if (phase) begin
        prdata_reg  <= {24'h00_0000, rd_next};
        pslverr_reg <= ~hit_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= MASK_RST;
      mcr_reg  <= MCR_RST;
    end else begin
      if (wr_mask) mask_reg <= pwdata[3:0];
      if (wr_mcr)  mcr_reg  <= pwdata[4:0];
    end
  end

  // Queue control: without the enable bit the rest of the write is void.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg  <= '0;
      trig_reg <= TRIG_RST;
    end else begin
      ctl_reg.rx_clr  <= 1'b0;
      ctl_reg.tx_clr  <= 1'b0;
      ctl_reg.rx_pop  <= rd_data;
      ctl_reg.tx_push <= wr_data;
      ctl_reg.msr_clr <= rd_msr;
      if (wr_data) ctl_reg.tx_data <= pwdata[7:0];
      if (wr_fcr) begin
        ctl_reg.fifo_en <= pwdata[F_EN];
        if (pwdata[F_EN]) begin
          ctl_reg.rx_clr <= pwdata[F_RXCLR];
          ctl_reg.tx_clr <= pwdata[F_TXCLR];
          trig_reg <= pwdata[F_TRIG+1:F_TRIG];
        end
      end
    end
  end

  // A new event in the cycle of a clearing read is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_reg    <= 1'b0;
      err_reg    <= 3'h0;
      herr_q_reg <= 3'h0;
    end else begin
      herr_q_reg <= stat.head_err;
      if (stat.overrun) ovr_reg <= 1'b1;
      else if (rd_lsr)  ovr_reg <= 1'b0;
      err_reg <= (rd_lsr ? 3'h0 : err_reg)
                 | (stat.head_err & ~herr_q_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // An empty transmit side idles high, so reset makes no false edge.
      txe_q_reg <= 1'b1;
      txr_reg   <= 1'b0;
    end else begin
      txe_q_reg <= stat.tx_empty;
      if (txr_set) txr_reg <= 1'b1;
      else if (rd_isr | wr_data) txr_reg <= 1'b0;
    end
  end

  assign tout_limit = 8'(TOUT_CHARS * {4'h0, stat.char_bits} + TOUT_BITS);
  assign tout_run = ctl_reg.fifo_en & rx_any & ~stat.rx_char_in & ~rd_data;
  assign tout_hit = tout_run & stat.bit_tick
                    & (tout_cnt_reg == tout_limit - 8'h01);

  // The timer only counts while data waits, so an idle queue never fires.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_cnt_reg <= 8'h00;
      tout_reg     <= 1'b0;
    end else begin
      if (!tout_run) tout_cnt_reg <= 8'h00;
      else if (stat.bit_tick && tout_cnt_reg != tout_limit)
        tout_cnt_reg <= tout_cnt_reg + 8'h01;
      if (tout_hit)     tout_reg <= 1'b1;
      else if (rd_data) tout_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_reg <= ISR_NONE;
      irq_reg <= 1'b0;
    end else begin
      isr_reg <= code_next;
      irq_reg <= mcr_reg[MCR_IRQ] & (code_next != ISR_NONE);
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign ctl     = ctl_reg;
  assign irq     = irq_reg;

  property p_polled;
    @(posedge pclk) disable iff (!presetn)
    mask_reg == MASK_RST |=> isr_reg == ISR_NONE && !irq_reg;
  endproperty
  a_polled: assert property (p_polled)
    else $error("source reported with all masks clear");

  property p_line_first;
    @(posedge pclk) disable iff (!presetn)
    line_p |=> isr_reg == ISR_LINE;
  endproperty
  a_line_first: assert property (p_line_first)
    else $error("line status not reported first");

  property p_tout_next;
    @(posedge pclk) disable iff (!presetn)
    !line_p && tout_p |=> isr_reg == ISR_TOUT;
  endproperty
  a_tout_next: assert property (p_tout_next)
    else $error("time-out not second in priority");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
    !mcr_reg[MCR_IRQ] |=> !irq_reg;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt line driven while withheld");

  property p_ovr_clear;
    @(posedge pclk) disable iff (!presetn)
    rd_lsr && !stat.overrun |=> !ovr_reg;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun survives line status read");

  property p_txr_clear;
    @(posedge pclk) disable iff (!presetn)
    (rd_isr || wr_data) && !txr_set |=> !txr_reg;
  endproperty
  a_txr_clear: assert property (p_txr_clear)
    else $error("transmit ready not cleared");

  property p_rxclr_pulse;
    @(posedge pclk) disable iff (!presetn)
    wr_fcr && pwdata[F_EN] && pwdata[F_RXCLR]
      |=> ctl_reg.rx_clr ##1 !ctl_reg.rx_clr;
  endproperty
  a_rxclr_pulse: assert property (p_rxclr_pulse)
    else $error("receive reset not a single pulse");

  property p_fcr_void;
    @(posedge pclk) disable iff (!presetn)
    wr_fcr && !pwdata[F_EN]
      |=> !ctl_reg.fifo_en && !ctl_reg.rx_clr && !ctl_reg.tx_clr
          && trig_reg == $past(trig_reg);
  endproperty
  a_fcr_void: assert property (p_fcr_void)
    else $error("control bits taken without enable");

  property p_tout_clear;
    @(posedge pclk) disable iff (!presetn)
    rd_data |=> !tout_reg;
  endproperty
  a_tout_clear: assert property (p_tout_clear)
    else $error("time-out survives data read");

  property p_ovr_set;
    @(posedge pclk) disable iff (!presetn)
    stat.overrun |=> ovr_reg;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun event lost");

  property p_txr_now;
    @(posedge pclk) disable iff (!presetn)
    wr_mask && pwdata[M_TXR] && !mask_reg[M_TXR] && stat.tx_empty
      |=> txr_reg;
  endproperty
  a_txr_now: assert property (p_txr_now)
    else $error("transmit ready not raised on enable");
endmodule // uic_ctrl
`default_nettype wire

// ===== uic_dp_model.sv
/*
  Behavioural serial datapath facing the interrupt and queue control block.
  Assumes the bench pulses rx_in, ovr_in and mdm_in one cycle each and
  holds herr_in as the error tag of the byte at the receive head.
*/
`timescale 1ns/100ps
`default_nettype none
module uic_dp_model
  import uic_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       rx_in,
  input  wire logic       ovr_in,
  input  wire logic       mdm_in,
  input  wire logic [2:0] herr_in,
  input  wire uic_ctl_t   ctl,
  output uic_stat_t       stat
);
  logic [7:0] lvl_reg;
  logic [3:0] delta_reg;
  logic       txe_reg, tick_reg, chr_reg, ovr_reg;
  // The transmit side never drains by itself, so it stalls until cleared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg   <= 8'h00;
      delta_reg <= 4'h0;
      txe_reg   <= 1'b1;
      tick_reg  <= 1'b0;
      chr_reg   <= 1'b0;
      ovr_reg   <= 1'b0;
    end else begin
      tick_reg <= ~tick_reg;
      chr_reg  <= rx_in;
      ovr_reg  <= ovr_in;
      if (ctl.rx_clr) lvl_reg <= 8'h00;
      else if (rx_in) lvl_reg <= lvl_reg + 8'h01;
      else if (ctl.rx_pop && lvl_reg != 8'h00) lvl_reg <= lvl_reg - 8'h01;
      if (ctl.tx_clr) txe_reg <= 1'b1;
      else if (ctl.tx_push) txe_reg <= 1'b0;
      if (mdm_in) delta_reg <= 4'h1;
      else if (ctl.msr_clr) delta_reg <= 4'h0;
    end
  end
  always_comb begin
    stat            = '0;
    stat.rx_level   = lvl_reg;
    stat.rx_char_in = chr_reg;
    stat.rx_data    = 8'ha5;
    stat.overrun    = ovr_reg;
    stat.head_err   = herr_in;
    stat.fifo_err   = |herr_in;
    stat.tx_empty   = txe_reg;
    stat.tx_idle    = txe_reg;
    stat.modem_status        = {4'h0, delta_reg};
    stat.bit_tick   = tick_reg;
    stat.char_bits  = 4'h2;
  end
endmodule // uic_dp_model
`default_nettype wire

// ===== uic_ctrl_tb.sv
/*
  Self-checking bench of the interrupt and queue control block.
  Assumes the datapath model stands on the status side.
*/
`timescale 1ns/100ps
`default_nettype none
module uic_ctrl_tb
  import uic_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        rx_in, ovr_in, mdm_in, err;
  logic [2:0]  herr_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  uic_stat_t   stat;
  uic_ctl_t    ctl;
  int          errors, n_compared;

  uic_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stat(stat),
    .ctl(ctl), .irq(irq));
  uic_dp_model model_u (.pclk(pclk), .presetn(presetn), .rx_in(rx_in),
    .ovr_in(ovr_in), .mdm_in(mdm_in), .herr_in(herr_in), .ctl(ctl),
    .stat(stat));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic close_out;
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [2:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {7'h00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] idx, input logic [7:0] exp,
                     input string name);
    apb(1'b0, idx, 8'h00);
    chk(name, {24'h000000, exp}, rd);
  endtask

  task automatic pulse_rx;
    @(posedge pclk) rx_in <= 1'b1;
    @(posedge pclk) rx_in <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_reset;
    rdc(IDX_ISR, 8'h01, "status");
    rdc(IDX_MASK, 8'h00, "mask");
    apb(1'b0, 3'h3, 8'h00);
    chk("slverr", 32'h1, {31'h0, err});
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_polled;
    apb(1'b1, IDX_ISR, 8'h01);
    @(posedge pclk);
    chk("fifo_en", 32'h1, {31'h0, ctl.fifo_en});
    rdc(IDX_ISR, 8'hc1, "status");
    rdc(IDX_LSR, 8'h60, "line");
  endtask

  task automatic t_txr;
    apb(1'b1, IDX_MASK, 8'h02);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, IDX_MCR, 8'h08);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(IDX_ISR, 8'hc2, "status");
    rdc(IDX_ISR, 8'hc1, "status");
    apb(1'b1, IDX_MASK, 8'h00);
    apb(1'b1, IDX_MASK, 8'h02);
    apb(1'b1, IDX_DATA, 8'h3c);
    rdc(IDX_ISR, 8'hc1, "status");
    apb(1'b1, IDX_ISR, 8'h05);
    repeat (2) @(posedge pclk);
    rdc(IDX_ISR, 8'hc2, "status");
    rdc(IDX_ISR, 8'hc1, "status");
  endtask

  task automatic t_rx_prio;
    apb(1'b1, IDX_MASK, 8'h05);
    pulse_rx();
    @(posedge pclk) ovr_in <= 1'b1;
    @(posedge pclk) ovr_in <= 1'b0;
    repeat (2) @(posedge pclk);
    rdc(IDX_ISR, 8'hc6, "status");
    rdc(IDX_LSR, 8'h63, "line");
    rdc(IDX_ISR, 8'hc4, "status");
    rdc(IDX_DATA, 8'ha5, "data");
    rdc(IDX_ISR, 8'hc1, "status");
  endtask

  task automatic t_mdm;
    apb(1'b1, IDX_MASK, 8'h08);
    @(posedge pclk) mdm_in <= 1'b1;
    @(posedge pclk) mdm_in <= 1'b0;
    repeat (2) @(posedge pclk);
    rdc(IDX_ISR, 8'hc0, "status");
    rdc(IDX_MSR, 8'h01, "modem");
    rdc(IDX_ISR, 8'hc1, "status");
  endtask

  task automatic t_herr;
    apb(1'b1, IDX_MASK, 8'h04);
    @(posedge pclk) herr_in <= 3'h1;
    repeat (2) @(posedge pclk);
    rdc(IDX_ISR, 8'hc6, "status");
    rdc(IDX_LSR, 8'he4, "line");
    rdc(IDX_ISR, 8'hc1, "status");
    @(posedge pclk) herr_in <= 3'h0;
    repeat (2) @(posedge pclk);
    rdc(IDX_LSR, 8'h60, "line");
  endtask

  task automatic t_tout;
    apb(1'b1, IDX_ISR, 8'h41);
    apb(1'b1, IDX_MASK, 8'h01);
    pulse_rx();
    repeat (30) @(posedge pclk);
    rdc(IDX_ISR, 8'hc1, "status");
    repeat (8) @(posedge pclk);
    rdc(IDX_ISR, 8'hcc, "status");
    rdc(IDX_DATA, 8'ha5, "data");
    rdc(IDX_ISR, 8'hc1, "status");
  endtask

  task automatic t_qclr;
    pulse_rx();
    apb(1'b1, IDX_ISR, 8'h03);
    repeat (2) @(posedge pclk);
    rdc(IDX_LSR, 8'h60, "line");
    apb(1'b1, IDX_ISR, 8'h02);
    rdc(IDX_ISR, 8'h01, "status");
    chk("fifo_en", 32'h0, {31'h0, ctl.fifo_en});
  endtask

  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, rx_in, ovr_in, mdm_in} = '0;
    herr_in = '0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_polled();
    t_txr();
    t_rx_prio();
    t_mdm();
    t_herr();
    t_tout();
    t_qclr();
    close_out();
  end
endmodule // uic_ctrl_tb
`default_nettype wire
